//--- hdl/otp_pkg.sv
package otp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] OTP_IDX_CTRL = 8'h18;
  localparam logic [7:0] OTP_IDX_P0LO = 8'h19;
  localparam logic [7:0] OTP_IDX_MIX = 8'h1a;
  localparam logic [7:0] OTP_IDX_P1HI = 8'h1b;
  localparam logic [7:0] OTP_IDX_TAGS = 8'h1c;
  localparam logic [7:0] OTP_IDX_BOOST = 8'h37;
  localparam int OTP_REG_W = 16;
  localparam int OTP_DATA_W = 24;
  localparam int OTP_TAG_W = 6;
  localparam int OTP_INC_LSB = 4;
  localparam int OTP_SEL_LSB = 2;
  localparam int OTP_EN_BIT = 1;
  localparam int OTP_TAGB_LSB = 8;
  localparam int OTP_TAGA_LSB = 0;
  localparam int OTP_BSEL_LSB = 1;
  localparam int OTP_BEN_BIT = 0;
  localparam logic [15:0] OTP_CTRL_MASK = 16'h00fe;
  localparam logic [15:0] OTP_TAGS_MASK = 16'h3f3f;
  localparam logic [15:0] OTP_BOOST_MASK = 16'h0007;
  localparam logic [15:0] OTP_RST_VAL = 16'h0000;
  localparam logic [1:0] OTP_SEL_RAMP = 2'h2;
  localparam logic [1:0] OTP_SEL_ALT = 2'h3;
  localparam logic [1:0] OTP_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] OTP_HSIZE_WORD = 3'h2;
  typedef enum logic [2:0] {
    OTP_FIXED = 3'b001,
    OTP_RAMP = 3'b010,
    OTP_ALT = 3'b100
  } otp_mode_t;
endpackage

//--- hdl/otp_regs.sv
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Ramp steps by increment field plus one
// - Select 0 or 1 gives constant pattern zero
// - Select 2 gives digital ramp
// - Select 3 alternates pattern zero and one
// - Enable bit substitutes pattern on channels 5-8
// - Enable clear passes conversion results through
// - Pattern zero from low word and mixed low byte
// - Pattern one from mixed high byte and high word
// - Tag bits 13-8 appended for channels 5-8
// - Tag bits 5-0 appended for channels 1-4
// - Pair select picks boost channel pair
// - Boost enable bit turns speed boost on
// - All registers reset to zero
module otp_regs
  import otp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sample_valid,
  input wire logic [OTP_DATA_W-1:0] sample_data,
  output logic out_valid,
  output logic [OTP_DATA_W+OTP_TAG_W-1:0] out_data,
  input wire logic grpa_valid,
  input wire logic [OTP_DATA_W-1:0] grpa_data,
  output logic grpa_out_valid,
  output logic [OTP_DATA_W+OTP_TAG_W-1:0] grpa_out_data,
  output logic boost_enable,
  output logic [3:0] boost_ch_lo,
  output logic [3:0] boost_ch_hi
);
  logic [15:0] ctrl_r, p0lo_r, mix_r, p1hi_r, tags_r, boost_r;
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [31:0] rdata_nxt;
  logic [7:0] a_idx;
  logic addr_ok;
  logic [OTP_DATA_W-1:0] pat0, pat1, ramp_r, sub_val;
  logic alt_r;
  logic [1:0] sel;
  logic en;
  logic [3:0] inc;
  otp_mode_t mode, mode_r;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign a_idx = haddr[9:2];
  assign addr_ok = hsel && hready && htrans == OTP_HTRANS_NONSEQ && haddr[1:0] == 2'b00
    && haddr[31:10] == 22'h0 && hsize == OTP_HSIZE_WORD;

  // Write data arrives one cycle after the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_idx_r <= a_idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= OTP_RST_VAL;
      p0lo_r <= OTP_RST_VAL;
      mix_r <= OTP_RST_VAL;
      p1hi_r <= OTP_RST_VAL;
      tags_r <= OTP_RST_VAL;
      boost_r <= OTP_RST_VAL;
    end else if (wr_pend_r) begin
      // Reserved bits are held at reset value
      case (wr_idx_r)
        OTP_IDX_CTRL: ctrl_r <= hwdata[15:0] & OTP_CTRL_MASK;
        OTP_IDX_P0LO: p0lo_r <= hwdata[15:0];
        OTP_IDX_MIX: mix_r <= hwdata[15:0];
        OTP_IDX_P1HI: p1hi_r <= hwdata[15:0];
        OTP_IDX_TAGS: tags_r <= hwdata[15:0] & OTP_TAGS_MASK;
        OTP_IDX_BOOST: boost_r <= hwdata[15:0] & OTP_BOOST_MASK;
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_nxt = 32'h0;
    case (a_idx)
      OTP_IDX_CTRL: rdata_nxt = {16'h0, ctrl_r};
      OTP_IDX_P0LO: rdata_nxt = {16'h0, p0lo_r};
      OTP_IDX_MIX: rdata_nxt = {16'h0, mix_r};
      OTP_IDX_P1HI: rdata_nxt = {16'h0, p1hi_r};
      OTP_IDX_TAGS: rdata_nxt = {16'h0, tags_r};
      OTP_IDX_BOOST: rdata_nxt = {16'h0, boost_r};
      default: rdata_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rdata_nxt;
    end
  end

  assign pat0 = {mix_r[7:0], p0lo_r};
  assign pat1 = {p1hi_r, mix_r[15:8]};
  assign sel = ctrl_r[OTP_SEL_LSB +: 2];
  assign en = ctrl_r[OTP_EN_BIT];
  assign inc = ctrl_r[OTP_INC_LSB +: 4];

  always_comb begin
    case (sel)
      OTP_SEL_RAMP: mode = OTP_RAMP;
      OTP_SEL_ALT: mode = OTP_ALT;
      default: mode = OTP_FIXED;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= OTP_FIXED;
    end else begin
      mode_r <= en ? mode : OTP_FIXED;
    end
  end

  // Ramp restarts when newly selected, wraps at the data width
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_r <= '0;
    end else if (!en || mode != OTP_RAMP) begin
      ramp_r <= '0;
    end else if (sample_valid) begin
      // First sample after entry shows zero and still advances
      ramp_r <= ramp_r + OTP_DATA_W'({1'b0, inc} + 5'h1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alt_r <= 1'b0;
    end else if (!en || mode != OTP_ALT) begin
      alt_r <= 1'b0;
    end else if (sample_valid) begin
      alt_r <= !alt_r;
    end
  end

  always_comb begin
    case (mode)
      OTP_RAMP: sub_val = ramp_r;
      OTP_ALT: sub_val = alt_r ? pat1 : pat0;
      OTP_FIXED: sub_val = pat0;
      default: sub_val = pat0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
      grpa_out_valid <= 1'b0;
      grpa_out_data <= '0;
    end else begin
      out_valid <= sample_valid;
      grpa_out_valid <= grpa_valid;
      if (sample_valid) begin
        out_data <= {en ? sub_val : sample_data,
          tags_r[OTP_TAGB_LSB +: OTP_TAG_W]};
      end
      if (grpa_valid) begin
        grpa_out_data <= {grpa_data, tags_r[OTP_TAGA_LSB +: OTP_TAG_W]};
      end
    end
  end

  assign boost_enable = boost_r[OTP_BEN_BIT];
  assign boost_ch_lo = 4'h1 + {2'b00, boost_r[OTP_BSEL_LSB +: 2]};
  assign boost_ch_hi = 4'h8 - {2'b00, boost_r[OTP_BSEL_LSB +: 2]};

  logic [OTP_DATA_W-1:0] prev_ramp_out;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_ramp_out <= '0;
    end else if (out_valid) begin
      prev_ramp_out <= out_data[OTP_DATA_W+OTP_TAG_W-1:OTP_TAG_W];
    end
  end

  // Checker state: a sample already taken in this ramp or alternate run
  logic ramp_seen_r;
  logic alt_seen_r;
  logic [3:0] ramp_inc_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_seen_r <= 1'b0;
      ramp_inc_r <= 4'h0;
    end else if (!en || mode != OTP_RAMP) begin
      ramp_seen_r <= 1'b0;
    end else if (sample_valid) begin
      ramp_seen_r <= 1'b1;
      ramp_inc_r <= inc;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alt_seen_r <= 1'b0;
    end else if (!en || mode != OTP_ALT) begin
      alt_seen_r <= 1'b0;
    end else if (sample_valid) begin
      alt_seen_r <= 1'b1;
    end
  end

  ramp_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_valid && en && mode == OTP_RAMP && ramp_seen_r
    |=> out_data[OTP_DATA_W+OTP_TAG_W-1:OTP_TAG_W] == OTP_DATA_W'(prev_ramp_out
      + OTP_DATA_W'({1'b0, ramp_inc_r} + 5'h1)))
    else $error("ramp step wrong");
  fixed_pat_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_valid && en && sel < OTP_SEL_RAMP
    |=> out_data[OTP_DATA_W+OTP_TAG_W-1:OTP_TAG_W] == $past(pat0))
    else $error("fixed pattern wrong");
  ramp_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_valid && en && sel == OTP_SEL_RAMP && !ramp_seen_r
    |=> out_data[OTP_DATA_W+OTP_TAG_W-1:OTP_TAG_W] == '0)
    else $error("ramp not from zero");
  alt_pat_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_valid && en && sel == OTP_SEL_ALT && mode_r == OTP_ALT && alt_r
    |=> out_data[OTP_DATA_W+OTP_TAG_W-1:OTP_TAG_W] == $past(pat1))
    else $error("alternate pattern wrong");
  alt_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_valid && en && sel == OTP_SEL_ALT && !alt_r
    |=> out_data[OTP_DATA_W+OTP_TAG_W-1:OTP_TAG_W] == $past(pat0))
    else $error("alternate pattern zero wrong");
  alt_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_valid && en && mode == OTP_ALT && !alt_seen_r
    |=> out_data[OTP_DATA_W+OTP_TAG_W-1:OTP_TAG_W] == $past(pat0))
    else $error("alternation not from pattern zero");
  pass_thru_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_valid && !en |=> out_valid
      && out_data[OTP_DATA_W+OTP_TAG_W-1:OTP_TAG_W] == $past(sample_data))
    else $error("conversion data not passed");
  tag_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_valid |=> out_data[OTP_TAG_W-1:0] == $past(tags_r[13:8]))
    else $error("group b tag wrong");
  tag_a_a: assert property (@(posedge hclk) disable iff (!hresetn)
    grpa_valid |=> grpa_out_data[OTP_TAG_W-1:0] == $past(tags_r[5:0]))
    else $error("group a tag wrong");
  grpa_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
    grpa_valid |=> grpa_out_data[OTP_DATA_W+OTP_TAG_W-1:OTP_TAG_W] == $past(grpa_data))
    else $error("group a data wrong");
  grpa_strobe_a: assert property (@(posedge hclk) disable iff (!hresetn)
    grpa_out_valid == $past(grpa_valid))
    else $error("group a strobe wrong");
  out_strobe_a: assert property (@(posedge hclk) disable iff (!hresetn)
    out_valid == $past(sample_valid))
    else $error("group b strobe wrong");
  boost_pair_a: assert property (@(posedge hclk) disable iff (!hresetn)
    boost_ch_lo + boost_ch_hi == 4'd9 && boost_ch_lo <= 4'd4)
    else $error("boost pair wrong");
  boost_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    boost_r[OTP_BSEL_LSB +: 2] == 2'h0 |-> boost_ch_lo == 4'h1 && boost_ch_hi == 4'h8)
    else $error("boost outer pair wrong");
  boost_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
    boost_r[OTP_BSEL_LSB +: 2] == 2'h3 |-> boost_ch_lo == 4'h4 && boost_ch_hi == 4'h5)
    else $error("boost inner pair wrong");
  reg_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && hwrite && a_idx == OTP_IDX_BOOST
    ##1 1'b1 |=> boost_enable == $past(hwdata[0]))
    else $error("boost enable not written");
  rsv_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_r & ~OTP_CTRL_MASK) == 16'h0 && (tags_r & ~OTP_TAGS_MASK) == 16'h0
      && (boost_r & ~OTP_BOOST_MASK) == 16'h0)
    else $error("reserved bits set");

  ramp_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
    sample_valid && mode_r == OTP_RAMP ##2 sample_valid && mode_r == OTP_RAMP);
  alt_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
    sample_valid && alt_r && mode_r == OTP_ALT);
  boost_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
    boost_enable && boost_ch_lo == 4'h4);
  ramp_new_c: cover property (@(posedge hclk) disable iff (!hresetn)
    sample_valid && en && mode == OTP_RAMP && !ramp_seen_r);
  fixed_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
    sample_valid && en && mode == OTP_FIXED);
endmodule

//--- sim/otp_host_model.sv
`timescale 1ns/1ps
module otp_host_model
  import otp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic b_valid,
  input wire logic [OTP_DATA_W+OTP_TAG_W-1:0] b_data,
  input wire logic a_valid,
  input wire logic [OTP_DATA_W+OTP_TAG_W-1:0] a_data,
  output logic [OTP_DATA_W+OTP_TAG_W-1:0] b_word,
  output logic [OTP_DATA_W+OTP_TAG_W-1:0] a_word,
  output logic [15:0] b_cnt,
  output logic [15:0] a_cnt
);
  // Capture words only on their valid pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_word <= '0;
      a_word <= '0;
      b_cnt <= '0;
      a_cnt <= '0;
    end else begin
      if (b_valid) begin
        b_word <= b_data;
        b_cnt <= b_cnt + 16'h1;
      end
      if (a_valid) begin
        a_word <= a_data;
        a_cnt <= a_cnt + 16'h1;
      end
    end
  end
endmodule

//--- sim/otp_regs_tb_top.sv
`timescale 1ns/1ps
module otp_regs_tb_top import otp_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sample_valid, grpa_valid;
  logic out_valid, grpa_out_valid, boost_enable, alt;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [23:0] sample_data, grpa_data, ramp;
  logic [29:0] out_data, grpa_out_data, b_word, a_word;
  logic [3:0] boost_ch_lo, boost_ch_hi;
  logic [15:0] b_cnt, a_cnt, n_smp;
  logic [15:0] mir [256];
  logic [7:0] ix;
  logic [7:0] tbl [7] = '{OTP_IDX_CTRL, OTP_IDX_P0LO, OTP_IDX_MIX, OTP_IDX_P1HI,
    OTP_IDX_TAGS, OTP_IDX_BOOST, 8'h20};
  integer seed = 32'h232978e7;
  int miscompares, n_checks;
  assign hready = hreadyout;
  otp_regs dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .sample_valid, .sample_data, .out_valid, .out_data,
    .grpa_valid, .grpa_data, .grpa_out_valid, .grpa_out_data, .boost_enable, .boost_ch_lo,
    .boost_ch_hi);
  otp_host_model host (.hclk, .hresetn, .b_valid(out_valid), .b_data(out_data),
    .a_valid(grpa_out_valid), .a_data(grpa_out_data), .b_word, .a_word, .b_cnt, .a_cnt);
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic complete_run;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] msk(input logic [7:0] i);
    case (i)
      OTP_IDX_CTRL: return OTP_CTRL_MASK;
      OTP_IDX_TAGS: return OTP_TAGS_MASK;
      OTP_IDX_BOOST: return OTP_BOOST_MASK;
      OTP_IDX_P0LO, OTP_IDX_MIX, OTP_IDX_P1HI: return 16'hffff;
      default: return 16'h0000;
    endcase
  endfunction
  // 0 off, 1 fixed, 2 ramp, 3 alternate
  function automatic logic [1:0] md(input logic [15:0] c);
    return !c[1] ? 2'h0 : (c[3] ? c[3:2] : 2'h1);
  endfunction
  function automatic logic [23:0] exp_b(input logic [23:0] raw);
    case (md(mir[OTP_IDX_CTRL]))
      2'h0: return raw;
      2'h1: return {mir[OTP_IDX_MIX][7:0], mir[OTP_IDX_P0LO]};
      2'h2: return ramp;
      default: return alt ? {mir[OTP_IDX_P1HI], mir[OTP_IDX_MIX][15:8]} :
        {mir[OTP_IDX_MIX][7:0], mir[OTP_IDX_P0LO]};
    endcase
  endfunction
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= OTP_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [15:0] v;
    v = d & msk(idx);
    xfer(1'b1, idx, {16'h0, v});
    if (idx == OTP_IDX_CTRL && md(v) != md(mir[idx])) begin
      ramp = '0;
      alt = 1'b0;
    end
    mir[idx] = v;
  endtask
  task automatic rdchk(input logic [7:0] idx);
    xfer(1'b0, idx, 32'h0);
    chk("reg", {16'h0, mir[idx]}, rd);
  endtask
  task automatic bchk;
    logic [1:0] s;
    s = mir[OTP_IDX_BOOST][2:1];
    #1;
    chk("boost_en", {31'h0, mir[OTP_IDX_BOOST][0]}, {31'h0, boost_enable});
    chk("boost_lo", 32'(s) + 32'h1, {28'h0, boost_ch_lo});
    chk("boost_hi", 32'h8 - 32'(s), {28'h0, boost_ch_hi});
  endtask
  task automatic smp(input logic [23:0] b, input logic [23:0] a);
    logic [23:0] e;
    e = exp_b(b);
    sample_valid <= 1'b1;
    sample_data <= b;
    grpa_valid <= 1'b1;
    grpa_data <= a;
    @(posedge hclk);
    sample_valid <= 1'b0;
    grpa_valid <= 1'b0;
    @(posedge hclk);
    #1;
    n_smp++;
    chk("out_b", {2'b0, e, mir[OTP_IDX_TAGS][13:8]}, {2'b0, b_word});
    chk("out_a", {2'b0, a, mir[OTP_IDX_TAGS][5:0]}, {2'b0, a_word});
    chk("n_out", {16'h0, n_smp}, {16'h0, b_cnt});
    chk("n_out_a", {16'h0, n_smp}, {16'h0, a_cnt});
    ramp = ramp + 24'(mir[OTP_IDX_CTRL][7:4]) + 24'h1;
    alt = ~alt;
  endtask
  initial begin
    #50000;
    miscompares++;
    complete_run;
  end
  initial begin
    {hresetn, hsel, hwrite, sample_valid, grpa_valid, alt} = '0;
    {haddr, hwdata, htrans, sample_data, grpa_data, ramp, n_smp} = '0;
    hsize = OTP_HSIZE_WORD;
    foreach (mir[i]) mir[i] = 16'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (tbl[i]) rdchk(tbl[i]);
    bchk;
    smp(24'habcdef, 24'h123456);
    wr(OTP_IDX_P0LO, 16'h5a5a);
    wr(OTP_IDX_MIX, 16'hc33c);
    wr(OTP_IDX_P1HI, 16'h0ff0);
    for (int s = 0; s < 4; s++) begin
      wr(OTP_IDX_CTRL, 16'((s * 5) << 4 | s << 2 | 2));
      repeat (3) smp(24'($random(seed)), 24'($random(seed)));
      wr(OTP_IDX_BOOST, 16'(s * 2 + 1));
      bchk;
    end
    wr(OTP_IDX_CTRL, 16'h00fa);
    repeat (4) smp(24'($random(seed)), 24'($random(seed)));
    for (int k = 0; k < 60; k++) begin
      ix = tbl[$unsigned($random(seed)) % 7];
      wr(ix, 16'($random(seed)));
      rdchk(tbl[$unsigned($random(seed)) % 7]);
      bchk;
      repeat (2) smp(24'($random(seed)), 24'($random(seed)));
    end
    complete_run;
  end
endmodule
